// ==== core/rperr_regs.sv ====
// Root port error message status, source ID, capability header and unit error registers
// Notes on behaviour
// - Message status bits 31:27 read the MSI vector offset, read only.
// - Fatal error message sets sticky clearable bit 6.
// - Non-fatal error message sets sticky clearable bit 5.
// - Bit 4 set when first logged uncorrectable message is fatal.
// - Uncorrectable message sets bit 2 when bit 2 is clear.
// - Uncorrectable message while bit 2 set sets bit 3.
// - Correctable message sets bit 0 when bit 0 is clear.
// - Correctable message while bit 0 set sets bit 1.
// - First uncorrectable message captures requester ID into source bits 31:16.
// - First correctable message captures requester ID into source bits 15:0.
// - Capability header bits 31:20 give the next capability pointer.
// - Header bits 19:16 version, bits 15:0 extended capability code.
// - Virtual pin interface fault sets unit bit 3, treated fatal.
// - I/O unit failure sets unit bit 2, treated fatal.
// - Crossing uncorrectable ECC sets unit bit 1, treated fatal.
// - Crossing correctable ECC sets unit bit 0, treated correctable.
// - Severity interrupt raised only when its command enable bit is set.
`timescale 1ns/10ps
`include "rperr_consts.svh"
module rperr_regs
   import rperr_pkg::*;
#(
   parameter logic [4:0] MSI_VECTOR_OFFSET = 5'h00,
   parameter logic [11:0] NEXT_CAP_LINK = 12'h000,
   // Arbitrary value
   parameter logic [3:0] CAP_VERSION = 4'h0,
   // Arbitrary value
   parameter logic [15:0] EXT_CAP_CODE = 16'h0000
) (
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic warm_reset_n,
   // Configuration access
   input wire rperr_cfg_t cfg,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   // Received error messages and unit faults
   input wire rperr_msg_t msg,
   input wire rperr_unit_t unit,
   // Severity interrupt requests
   output logic irq_fatal,
   output logic irq_uncorrectable,
   output logic irq_correctable,
   // Unit fault classification
   output logic unit_fatal,
   output logic unit_correctable
);
   // Two kinds of state live here. The log (status flags, source IDs, unit flags)
   // is sticky and only the power-on reset clears it; the command enables, the
   // read answer and the interrupt pulses follow the ordinary reset as well.
   // Hardware events always beat a software write in the same cycle, so a clear
   // that races an incoming error never hides it.

   // Command enables: fatal, uncorrectable, correctable
   logic [2:0] cmd_d;
   logic [2:0] cmd_q;
   // Message status flags, kept in the clearable bit bank
   logic [6:0] sts_set;
   logic [6:0] sts_clr;
   logic [6:0] sts;
   // Requester IDs of the first errors of each class
   logic [15:0] unc_id_d;
   logic [15:0] unc_id_q;
   logic [15:0] corr_id_d;
   logic [15:0] corr_id_q;
   // Internal unit fault flags
   logic [3:0] unit_d;
   logic [3:0] unit_q;
   // Registered read answer
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic ack_d;
   logic ack_q;
   // Interrupt request pulses: fatal, uncorrectable, correctable
   logic [2:0] irq_d;
   logic [2:0] irq_q;
   // Message class of the current cycle
   logic is_unc;
   logic is_corr;
   logic is_fatal;
   logic is_nonfatal;
   // Writes decoded per register
   logic wr_cmd;
   logic wr_sts;
   logic wr_unit;
   // Whole register words as software sees them
   logic [31:0] cmd_word;
   logic [31:0] sts_word;
   logic [31:0] srcid_word;
   logic [31:0] cap_word;
   logic [31:0] unit_word;

   // Byte enables widened to a bit mask, so a partial write touches only its lanes
   function automatic logic [31:0] rperr_bemask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // True when the access is a write aimed at the given offset
   function automatic logic rperr_hit(input rperr_cfg_t c, input logic [11:0] off);
      return c.wr && (c.addr == off);
   endfunction

   // Classify the received message; an undefined severity code is handled as
   // uncorrectable and non-fatal, so it is logged rather than dropped
   always_comb begin
      is_fatal = msg.valid && (msg.severity == RPERR_SEV_FATAL);
      is_corr = msg.valid && (msg.severity == RPERR_SEV_CORR);
      is_unc = msg.valid && (msg.severity != RPERR_SEV_CORR);
      is_nonfatal = is_unc && !is_fatal;
   end

   // Writes to each register; command and unit writes ride on the low byte lane
   always_comb begin
      wr_cmd = rperr_hit(cfg, `RPERR_OFF_CMD) && cfg.be[0];
      wr_sts = rperr_hit(cfg, `RPERR_OFF_MSGSTS);
      wr_unit = rperr_hit(cfg, `RPERR_OFF_UNITERR) && cfg.be[0];
   end

   // Status set terms; first and further flags judge the stored first flag, so
   // one message never sets both of a pair
   always_comb begin
      sts_set = '0;
      sts_set[`RPERR_BIT_FATAL] = is_fatal;
      sts_set[`RPERR_BIT_NONFATAL] = is_nonfatal;
      sts_set[`RPERR_BIT_FIRST_SEVERE] = is_fatal && !sts[`RPERR_BIT_FIRST_UNC];
      sts_set[`RPERR_BIT_NEXT_UNC] = is_unc && sts[`RPERR_BIT_FIRST_UNC];
      sts_set[`RPERR_BIT_FIRST_UNC] = is_unc && !sts[`RPERR_BIT_FIRST_UNC];
      sts_set[`RPERR_BIT_NEXT_CORR] = is_corr && sts[`RPERR_BIT_FIRST_CORR];
      sts_set[`RPERR_BIT_FIRST_CORR] = is_corr && !sts[`RPERR_BIT_FIRST_CORR];
   end

   // Status clear terms; only written ones on enabled lanes clear, reserved bits masked
   always_comb begin
      sts_clr = '0;
      if (wr_sts) begin
         sts_clr = 7'(cfg.wdata & rperr_bemask(cfg.be) & `RPERR_MSGSTS_W1C_MASK);
      end
   end

   // Clearable flags; reached only by the power-on reset, so they are sticky
   rperr_w1c_bits #(
      .WIDTH(7)
   ) u_sts (
      .clk(clk),
      .reset_n(reset_n),
      .set(sts_set),
      .clr(sts_clr),
      .flags(sts)
   );

   // Source IDs latch only while the matching first flag is clear; a later message
   // of the same class leaves the first source in place for software
   always_comb begin
      unc_id_d = unc_id_q;
      corr_id_d = corr_id_q;
      if (is_unc && !sts[`RPERR_BIT_FIRST_UNC]) begin
         unc_id_d = msg.requester;
      end
      if (is_corr && !sts[`RPERR_BIT_FIRST_CORR]) begin
         corr_id_d = msg.requester;
      end
   end

   // Source IDs: power-on reset only, ordinary resets keep the log
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unc_id_q <= 16'h0000;
         corr_id_q <= 16'h0000;
      end else begin
         unc_id_q <= unc_id_d;
         corr_id_q <= corr_id_d;
      end
   end

   // Unit flags take a written value, then any fault of this cycle is ORed in, so a
   // fault that meets a clearing write is still recorded
   always_comb begin
      unit_d = unit_q;
      if (wr_unit) begin
         unit_d = 4'(cfg.wdata & `RPERR_UNITERR_MASK);
      end
      unit_d[3] = unit_d[3] | unit.virtual_pin_if_fault;
      unit_d[2] = unit_d[2] | unit.io_unit_failure;
      unit_d[1] = unit_d[1] | unit.crossing_uncorrectable_ecc;
      unit_d[0] = unit_d[0] | unit.crossing_correctable_ecc;
   end

   // Unit flags: power-on reset only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unit_q <= 4'h0;
      end else begin
         unit_q <= unit_d;
      end
   end

   // Command enables; bits above the three enables are not stored
   always_comb begin
      cmd_d = cmd_q;
      if (wr_cmd) begin
         cmd_d = 3'(cfg.wdata & `RPERR_CMD_MASK);
      end
   end

   // Command enables are not sticky: the ordinary reset clears them too
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= 3'h0;
      end else if (!warm_reset_n) begin
         cmd_q <= 3'h0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // Interrupt requests gate each class with its stored enable; an enable written
   // in the same cycle as a message takes effect from the next message on.
   // A fatal message is also uncorrectable, so it may raise two requests at once
   always_comb begin
      irq_d = 3'h0;
      irq_d[2] = is_fatal && cmd_q[2];
      irq_d[1] = is_unc && cmd_q[1];
      irq_d[0] = is_corr && cmd_q[0];
   end

   // Interrupt pulses last one cycle and are dropped by either reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 3'h0;
      end else if (!warm_reset_n) begin
         irq_q <= 3'h0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Register words as read; every word starts from zero, so reserved bits read zero
   always_comb begin
      // Command word
      cmd_word = `RPERR_RESET_ZERO;
      cmd_word[2:0] = cmd_q;
      // Message status word
      sts_word = `RPERR_RESET_ZERO;
      sts_word[31:27] = MSI_VECTOR_OFFSET;
      sts_word[6:0] = sts;
      // Source ID word
      srcid_word = `RPERR_RESET_ZERO;
      srcid_word[31:16] = unc_id_q;
      srcid_word[15:0] = corr_id_q;
      // Capability header word, fixed at build time
      cap_word = `RPERR_RESET_ZERO;
      cap_word[31:20] = NEXT_CAP_LINK;
      cap_word[19:16] = CAP_VERSION;
      cap_word[15:0] = EXT_CAP_CODE;
      // Unit fault word
      unit_word = `RPERR_RESET_ZERO;
      unit_word[3:0] = unit_q;
   end

   // Read mux; unmapped offsets and writes answer zero, so read data is clean
   // whenever no read is being answered
   always_comb begin
      rdata_d = `RPERR_RESET_ZERO;
      ack_d = cfg.rd || cfg.wr;
      if (cfg.rd) begin
         unique case (cfg.addr)
            `RPERR_OFF_CMD: rdata_d = cmd_word;
            `RPERR_OFF_MSGSTS: rdata_d = sts_word;
            `RPERR_OFF_SRCID: rdata_d = srcid_word;
            `RPERR_OFF_CAPHDR: rdata_d = cap_word;
            `RPERR_OFF_UNITERR: rdata_d = unit_word;
            default: rdata_d = `RPERR_RESET_ZERO;
         endcase
      end
   end

   // Answer registers; a read in flight when the ordinary reset hits is dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h00000000;
         ack_q <= 1'b0;
      end else if (!warm_reset_n) begin
         rdata_q <= 32'h00000000;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end

   // Outputs straight from flops
   assign cfg_rdata = rdata_q;
   assign cfg_ack = ack_q;
   assign irq_fatal = irq_q[2];
   assign irq_uncorrectable = irq_q[1];
   assign irq_correctable = irq_q[0];
   // Unit fault classes; a flag stays visible here until software clears it
   assign unit_fatal = |unit_q[3:1];
   assign unit_correctable = unit_q[0];
endmodule

// ==== pkg/rperr_consts.svh ====
// Register offsets, field positions and reset values of the root port error log bank
`ifndef RPERR_CONSTS_SVH
`define RPERR_CONSTS_SVH
`define RPERR_OFF_CMD 12'h12C
`define RPERR_OFF_MSGSTS 12'h130
`define RPERR_OFF_SRCID 12'h134
`define RPERR_OFF_CAPHDR 12'h140
`define RPERR_OFF_UNITERR 12'h144
`define RPERR_BIT_FIRST_CORR 0
`define RPERR_BIT_NEXT_CORR 1
`define RPERR_BIT_FIRST_UNC 2
`define RPERR_BIT_NEXT_UNC 3
`define RPERR_BIT_FIRST_SEVERE 4
`define RPERR_BIT_NONFATAL 5
`define RPERR_BIT_FATAL 6
`define RPERR_MSGSTS_W1C_MASK 32'h0000007F
`define RPERR_UNITERR_MASK 32'h0000000F
`define RPERR_CMD_MASK 32'h00000007
`define RPERR_RESET_ZERO 32'h00000000
`endif

// ==== pkg/rperr_pkg.sv ====
// Types shared by the root port error log bank
package rperr_pkg;
   // Error message received from a downstream device
   typedef struct packed {
      logic valid;
      logic [1:0] severity;
      logic [15:0] requester;
   } rperr_msg_t;
   typedef enum logic [1:0] {
      RPERR_SEV_CORR = 2'h0,
      RPERR_SEV_NONFATAL = 2'h1,
      RPERR_SEV_FATAL = 2'h2
   } rperr_sev_t;
   // Configuration access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } rperr_cfg_t;
   // Internal unit fault pulses
   typedef struct packed {
      logic virtual_pin_if_fault;
      logic io_unit_failure;
      logic crossing_uncorrectable_ecc;
      logic crossing_correctable_ecc;
   } rperr_unit_t;
endpackage

// ==== core/rperr_w1c_bits.sv ====
// Sticky status bits with set priority over write-one-to-clear
`timescale 1ns/10ps
module rperr_w1c_bits
   import rperr_pkg::*;
#(
   parameter int WIDTH = 7
) (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic reset_n,
   // Set and clear requests
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   // Stored flags
   output logic [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_d;
   logic [WIDTH-1:0] flags_q;

   // Set wins so an event in the clearing cycle is never lost
   always_comb begin
      flags_d = (flags_q & ~clr) | set;
   end

   // Only power-on reset reaches these flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;
endmodule

// ==== testbench/rperr_regs_sva.sv ====
// Port-level checks of the root port error log bank
`timescale 1ns/10ps
module rperr_regs_sva
   import rperr_pkg::*;
#(
   parameter logic [11:0] NEXT_CAP_LINK = 12'h000,
   parameter logic [3:0] CAP_VERSION = 4'h0,
   parameter logic [15:0] EXT_CAP_CODE = 16'h0000
) (
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic warm_reset_n,
   // Access
   input wire rperr_cfg_t cfg,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   // Events and flags
   input wire rperr_msg_t msg,
   input wire rperr_unit_t unit,
   input wire logic irq_fatal,
   input wire logic irq_uncorrectable,
   input wire logic irq_correctable,
   input wire logic unit_fatal,
   input wire logic unit_correctable
);
   // Warm reset wipes answers and pulses, so it blanks the checks as well
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !warm_reset_n);
   sequence s_cap_rd;
      cfg.rd && cfg.addr == 12'h140;
   endsequence
   a_cap_header: assert property (s_cap_rd |=>
      cfg_rdata == {NEXT_CAP_LINK, CAP_VERSION, EXT_CAP_CODE}) else $error("cap header");
   a_rdata_quiet: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
      else $error("rdata idle");
   a_irq_severe: assert property (irq_fatal |->
      $past(msg.valid && msg.severity == RPERR_SEV_FATAL)) else $error("irq fatal");
   a_irq_mild: assert property (irq_correctable |->
      $past(msg.valid && msg.severity == RPERR_SEV_CORR)) else $error("irq corr");
   a_irq_unc_cause: assert property (irq_uncorrectable |->
      $past(msg.valid && msg.severity != RPERR_SEV_CORR)) else $error("irq unc");
   a_unit_severe: assert property ((unit.virtual_pin_if_fault || unit.io_unit_failure
      || unit.crossing_uncorrectable_ecc) |=> unit_fatal) else $error("unit fatal");
   a_unit_mild: assert property (unit.crossing_correctable_ecc |=> unit_correctable)
      else $error("unit corr");
   a_unit_sticky: assert property (unit_fatal && !cfg.wr && !$past(cfg.wr) |=> unit_fatal)
      else $error("unit sticky");
endmodule
bind rperr_regs rperr_regs_sva #(.NEXT_CAP_LINK(NEXT_CAP_LINK), .CAP_VERSION(CAP_VERSION),
   .EXT_CAP_CODE(EXT_CAP_CODE)) rperr_regs_sva_i (.clk(clk), .reset_n(reset_n),
   .warm_reset_n(warm_reset_n), .cfg(cfg), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
   .msg(msg), .unit(unit), .irq_fatal(irq_fatal), .irq_uncorrectable(irq_uncorrectable),
   .irq_correctable(irq_correctable), .unit_fatal(unit_fatal),
   .unit_correctable(unit_correctable));

// ==== testbench/rperr_peer.sv ====
// Downstream device model that posts error messages
`timescale 1ns/10ps
module rperr_peer
   import rperr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Message lines toward the root port
   output rperr_msg_t msg
);
   initial msg = '0;
   // Idle fields show inverted junk so a stale value is never taken for a new one
   task automatic send(input logic [1:0] sev, input logic [15:0] id, input int gap);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      msg = '{1'b1, sev, id};
      @(negedge clk);
      msg = '{1'b0, ~sev, ~id};
   endtask
endmodule

// ==== testbench/root_port_error_log_regs_tb_top.sv ====
// Self-checking bench for the root port error log bank
`timescale 1ns/10ps
module root_port_error_log_regs_tb_top;
   import rperr_pkg::*;
   logic clk = 0, reset_n = 0, warm_reset_n = 1, ack, irf, iru, irc, uf, uc;
   logic [31:0] rdata, sts = 0, sid = 0;
   rperr_cfg_t cfg = '0;
   rperr_unit_t unit = '0;
   rperr_msg_t msg;
   logic [2:0] en;
   logic [3:0] acc_be = 4'hF;
   int err_count = 0, tests_run = 0, cyc = 0, s;
   initial forever #20 clk = ~clk;
   // Run should need a few hundred cycles
   always @(posedge clk) if (++cyc > 3000) begin
      err_count++;
      print_verdict();
   end
   rperr_peer rperr_peer_i (.clk(clk), .msg(msg));
   rperr_regs #(.MSI_VECTOR_OFFSET(5'h15), .NEXT_CAP_LINK(12'hA5C), .CAP_VERSION(4'h3),
      .EXT_CAP_CODE(16'h1B2D)) rperr_regs_i (.clk(clk), .reset_n(reset_n),
      .warm_reset_n(warm_reset_n), .cfg(cfg), .cfg_rdata(rdata), .cfg_ack(ack), .msg(msg),
      .unit(unit), .irq_fatal(irf), .irq_uncorrectable(iru), .irq_correctable(irc),
      .unit_fatal(uf), .unit_correctable(uc));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // One-cycle access, judged against the ack it rides on
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, e);
      @(negedge clk);
      cfg = '{~w, w, a, d, acc_be};
      @(negedge clk);
      cfg = '0;
      chk("ack", 1, ack);
      if (!w) chk("rdata", e, rdata);
   endtask
   // Post a message, check the pulses, then advance the model
   task automatic post(input int sv, input logic [15:0] i, input logic [2:0] en);
      rperr_peer_i.send(sv[1:0], i, sv);
      chk("irq_fatal", en[2] && sv == 2, irf);
      chk("irq_corr", en[0] && sv == 0, irc);
      chk("irq_unc", en[1] && sv != 0, iru);
      if (sv == 0) begin
         if (!sts[0]) sid[15:0] = i;
         sts |= sts[0] ? 2 : 1;
      end else begin
         sts |= (sv == 2) ? 32'h40 : 32'h20;
         if (!sts[2]) sid[31:16] = i;
         sts |= sts[2] ? 8 : ((sv == 2) ? 32'h14 : 4);
      end
      acc(0, 12'h130, 0, {5'h15, sts[26:0]});
      acc(0, 12'h134, 0, sid);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      s = $urandom(7);
      repeat (3) @(posedge clk);
      @(negedge clk) reset_n = 1;
      acc(1, 12'h134, 32'hFFFFFFFF, 0);
      acc(0, 12'h130, 0, 32'hA8000000);
      acc(0, 12'h134, 0, 0);
      acc(0, 12'h140, 0, 32'hA5C31B2D);
      acc(0, 12'h144, 0, 0);
      acc(0, 12'h150, 0, 0);
      $display("reset values done");
      acc(1, 12'h12C, 7, 0);
      repeat (16) begin
         en = 3'($urandom);
         acc(1, 12'h12C, {29'h0, en}, 0);
         acc(0, 12'h12C, 0, {29'h0, en});
         post($urandom_range(3), 16'($urandom), en);
      end
      $display("random messages done");
      acc(1, 12'h130, 0, 0);
      acc(0, 12'h130, 0, {5'h15, sts[26:0]});
      acc_be = 4'hE;
      acc(1, 12'h130, 32'hFFFFFFFF, 0);
      acc_be = 4'hF;
      acc(0, 12'h130, 0, {5'h15, sts[26:0]});
      acc(1, 12'h130, 32'hFFFFFFFF, 0);
      sts = 0;
      acc(0, 12'h130, 0, 32'hA8000000);
      $display("clear done");
      @(negedge clk) warm_reset_n = 0;
      @(negedge clk) warm_reset_n = 1;
      acc(0, 12'h134, 0, sid);
      acc(0, 12'h12C, 0, 0);
      for (s = 0; s < 4; s++) post((s + 2) % 4, 16'($urandom), 0);
      $display("warm reset done");
      for (s = 0; s < 4; s++) begin
         @(negedge clk) unit = rperr_unit_t'(4'(1 << s));
         @(negedge clk) unit = '0;
         acc(0, 12'h144, 0, (32'h2 << s) - 1);
         chk("unit_fatal", s > 0, uf);
         chk("unit_corr", 1, uc);
      end
      acc(1, 12'h144, 0, 0);
      acc(0, 12'h144, 0, 0);
      $display("unit faults done");
      print_verdict();
   end
endmodule
